/* src/tmmu_match.sv */
// Comparator for one buffer entry: page pair, space identifier and the
// even/odd selection. Purely combinational, fed from the main module.
`timescale 1ns/10ps
`default_nettype none

module tmmu_match (
    input  wire tmmu_pkg::tmmu_entry_t entry,
    input  wire logic [31:12]          addr,
    input  wire logic [7:0]            space,
    output logic                       hit,
    output logic                       odd
);
    import tmmu_pkg::*;

    logic [18:0] care;                                 // Pair bits that compare
    logic [13:0] ext;                                  // Mask over bits 25:12
    logic [12:0] sel;                                  // One-hot odd select

    // ------------------------------------------------------------------
    // Compare and select
    // ------------------------------------------------------------------
    always_comb begin
        care = ~{7'h00, entry.mask};
        ext  = {1'b0, entry.mask, 1'b1};
        sel  = ext[12:0] & ~ext[13:1];
        // Unmasked bits equal and space ids equal or global
        hit  = (((addr[31:13] ^ entry.page_pair_number) & care) == 19'h00000) &&
               (entry.global || (entry.space_identifier == space));
        // Bit just below the lowest unmasked pair bit picks the half
        odd  = |(addr[24:12] & sel);
    end

endmodule

`default_nettype wire

/* src/tmmu_pkg.sv */
// Package for the translation unit: register numbers, field positions,
// reset values and the structs that carry entries, commands and results.
// Assumes one processor clock domain shared by the unit and the pipeline.
package tmmu_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          NUM_ENTRIES   = 16;        // Buffer depth
    localparam int          ENT_IDX_W     = 4;         // Bits to name an entry
    localparam logic [3:0]  RND_UPPER     = 4'hF;      // Highest entry number
    localparam logic [3:0]  RND_RESET     = 4'hF;      // Counter after reset
    localparam logic [5:0]  WIRED_RESET   = 6'h00;     // Locked entries after reset

    // ------------------------------------------------------------------
    // Register numbers
    // ------------------------------------------------------------------
    localparam logic [4:0]  REG_SELECTOR  = 5'h00;     // tlb_entry_selector
    localparam logic [4:0]  REG_REPL      = 5'h01;     // replacement_counter_reg
    localparam logic [4:0]  REG_EVEN_LO   = 5'h02;     // even_page_low_half
    localparam logic [4:0]  REG_ODD_LO    = 5'h03;     // odd_page_low_half
    localparam logic [4:0]  REG_PT_PTR    = 5'h04;     // page_table_pointer
    localparam logic [4:0]  REG_PAGE_SEL  = 5'h05;     // page_size_select
    localparam logic [4:0]  REG_LOCKED    = 5'h06;     // locked_entry_bound
    localparam logic [4:0]  REG_FAULT_VA  = 5'h08;     // faulting_vaddr
    localparam logic [4:0]  REG_HIGH      = 5'h0A;     // entry_high_half

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          SEL_PROBE_BIT = 31;        // Probe failure flag
    localparam int          SEL_IDX_MSB   = 5;         // Six-bit index field
    localparam int          LO_FRAME_MSB  = 25;        // Frame number
    localparam int          LO_FRAME_LSB  = 6;
    localparam int          LO_CACHE_MSB  = 5;         // Cache policy
    localparam int          LO_CACHE_LSB  = 3;
    localparam int          LO_DIRTY_BIT  = 2;         // Write enable
    localparam int          LO_VALID_BIT  = 1;         // Page valid
    localparam int          LO_GLOBAL_BIT = 0;         // Ignore space id
    localparam int          MASK_MSB      = 24;        // Page mask field
    localparam int          MASK_LSB      = 13;
    localparam int          HI_PAIR_MSB   = 31;        // Page pair number
    localparam int          HI_PAIR_LSB   = 13;
    localparam int          HI_SPACE_MSB  = 7;         // Space identifier
    localparam int          LOCKED_MSB    = 5;         // Locked-entry bound
    localparam int          REPL_MSB      = 3;         // Counter field

    // ------------------------------------------------------------------
    // Cache policy codes, 4 to 7 reserved
    // ------------------------------------------------------------------
    localparam logic [2:0]  CACHE_WT_NOALLOC = 3'h0;   // Write-through, no allocate
    localparam logic [2:0]  CACHE_WT_ALLOC   = 3'h1;   // Write-through, allocate
    localparam logic [2:0]  CACHE_UNCACHED   = 3'h2;   // Uncached
    localparam logic [2:0]  CACHE_WB         = 3'h3;   // Write-back

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [19:0] frame_number;                     // Physical frame
        logic [2:0]  cache;                            // Cache policy
        logic        dirty;                            // Writable
        logic        valid;                            // Page valid
    } tmmu_page_t;

    typedef struct packed {
        tmmu_page_t  page;                             // Frame and attributes
        logic        global;                           // Global attribute
    } tmmu_lo_t;

    typedef struct packed {
        logic [11:0] mask;                             // Address bits 24:13
        logic [18:0] page_pair_number;                 // Address bits 31:13
        logic [7:0]  space_identifier;                 // Address space
        logic        global;                           // AND of both halves
        tmmu_page_t  even;                             // Even page
        tmmu_page_t  odd;                              // Odd page
    } tmmu_entry_t;

    typedef struct packed {
        logic        probe_op;                         // Search by high half
        logic        indexed_read_op;                  // Entry to registers
        logic        indexed_write_op;                 // Registers to entry
        logic        random_write_op;                  // Registers to counter slot
    } tmmu_op_t;

    typedef struct packed {
        logic        valid;                            // Translation request
        logic        store;                            // Store, else load
        logic [31:0] vaddr;                            // Virtual address
    } tmmu_xreq_t;

    typedef struct packed {
        logic        valid;                            // Result present
        logic [31:0] paddr;                            // Physical address
        logic [2:0]  cache;                            // Cache policy of page
        logic        refill;                           // No matching entry
        logic        invalid;                          // Page not valid
        logic        modified;                         // Store to protected page
        logic        load_miss_exc;                    // Fault on a load
        logic        store_miss_exc;                   // Fault on a store
    } tmmu_xres_t;

    typedef struct packed {
        logic [3:0]  count;                            // Replacement counter
    } tmmu_rnd_t;

endpackage

/* src/tmmu_repl.sv */
// Replacement counter: counts down over retired instructions between the
// locked-entry bound and the top entry. Assumes same-clock inputs.
`timescale 1ns/10ps
`default_nettype none

module tmmu_repl (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       instr_valid,
    input  wire logic       bound_we,
    input  wire logic [5:0] bound,
    output logic [3:0]      count
);
    import tmmu_pkg::*;

    tmmu_rnd_t s;                                      // Current state
    tmmu_rnd_t next_s;                                 // Next state

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_s = s;
        if (bound_we) begin
            next_s.count = RND_UPPER;
        end else if (instr_valid) begin
            if ({2'b00, s.count} <= bound) begin
                next_s.count = RND_UPPER;
            end else begin
                next_s.count = s.count - 4'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s.count <= RND_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign count = s.count;

endmodule

`default_nettype wire

/* src/tmmu_top.sv */
// Translation unit: 16-entry associative buffer, its control registers,
// the four buffer instructions and load/store translation with faults.
// Assumes the pipeline drives every input from the same processor clock.
//
// Behaviour
// - Sixteen entries, fully associative, paired pages
// - Offset 12 to 24 bits by page size
// - Global needs both halves' global bits set
// - Three-bit cache policy, codes 4-7 reserved
// - Invalid page gives miss fault, no translation
// - Store needs dirty bit, else protection fault
// - Reserved fields written zero, read as zero
// - Selector: six-bit index, probe flag at top
// - Failed probe sets flag, success clears it
// - Indexed read and write use selector index
// - Counter read-only, four bits, counts down
// - Counter steps only on valid instructions
// - Counter stays between locked bound and 15
// - Counter set to 15 on reset, bound write
// - Random write uses counter slot; counter readable
// - Low halves carry even and odd pages
// - Every entry field maps to a register field
// - All four instructions use high half
// - Refill, invalid, modified faults to pipeline
// - Locked bound cleared at reset
// - Page mask selects compared bits 24:13
// - Fault loads high half with pair number
// - Faulting address frozen while exception level set
`timescale 1ns/10ps
`default_nettype none

module tmmu_top (
    input  wire logic                 CLK,
    input  wire logic                 NRST,
    input  wire logic                 REG_WE,
    input  wire logic                 REG_RE,
    input  wire logic [4:0]           REG_NUM,
    input  wire logic [31:0]          REG_WDATA,
    output logic [31:0]               REG_RDATA,
    output logic                      REG_RVALID,
    input  wire tmmu_pkg::tmmu_op_t   OP,
    input  wire logic                 INSTR_VALID,
    input  wire logic                 EXCEPTION_LEVEL_BIT,
    input  wire tmmu_pkg::tmmu_xreq_t XREQ,
    output var  tmmu_pkg::tmmu_xres_t XRES
);
    import tmmu_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        tmmu_entry_t [NUM_ENTRIES-1:0] tlb;            // Buffer entries
        logic                          probe_fail;     // Selector top bit
        logic [5:0]                    index;          // Selector index
        tmmu_lo_t                      even_lo;        // even_page_low_half
        tmmu_lo_t                      odd_lo;         // odd_page_low_half
        logic [11:0]                   mask;           // page_size_select
        logic [5:0]                    locked;         // locked_entry_bound
        logic [31:0]                   fault_va;       // faulting_vaddr
        logic [18:0]                   hi_pair;        // High half pair
        logic [7:0]                    hi_space;       // High half space id
        logic [31:0]                   rdata;          // Read data
        logic                          rvalid;         // Read answer strobe
        tmmu_xres_t                    xres;           // Translation result
    } tmmu_state_t;

    tmmu_state_t s;                                    // Current state
    tmmu_state_t next_s;                               // Next state

    logic [NUM_ENTRIES-1:0] hit_vec;                   // Per-entry hit
    logic [NUM_ENTRIES-1:0] odd_vec;                   // Per-entry odd select
    logic [31:12]           cmp_addr;                  // Address compared
    logic [3:0]             rnd_count;                 // Replacement counter
    logic                   locked_we;                 // Bound register write
    logic                   any_hit;                   // Some entry matched
    logic [3:0]             hit_idx;                   // Lowest matching entry
    logic [31:0]            rd_word;                   // Selected register
    tmmu_entry_t            new_entry;                 // Entry built from regs

    // ------------------------------------------------------------------
    // Comparators
    // ------------------------------------------------------------------
    // Probe compares the high half, translation the request address
    assign cmp_addr = OP.probe_op ? {s.hi_pair, 1'b0} : XREQ.vaddr[31:12];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_ENTRIES; gi = gi + 1) begin : g_cmp
            tmmu_match u_match (
                .entry (s.tlb[gi]),
                .addr  (cmp_addr),
                .space (s.hi_space),
                .hit   (hit_vec[gi]),
                .odd   (odd_vec[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Replacement counter
    // ------------------------------------------------------------------
    assign locked_we = REG_WE && (REG_NUM == REG_LOCKED);

    tmmu_repl u_repl (
        .clk         (CLK),
        .nrst        (NRST),
        .instr_valid (INSTR_VALID),
        .bound_we    (locked_we),
        .bound       (s.locked),
        .count       (rnd_count)
    );

    // ------------------------------------------------------------------
    // Hit encoder, lowest entry wins
    // ------------------------------------------------------------------
    always_comb begin
        any_hit = |hit_vec;
        hit_idx = 4'h0;
        for (int i = NUM_ENTRIES - 1; i >= 0; i--) begin
            if (hit_vec[i]) begin
                hit_idx = i[3:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Entry assembled from the registers for both write instructions
    // ------------------------------------------------------------------
    always_comb begin
        new_entry.mask             = s.mask;
        new_entry.page_pair_number = s.hi_pair;
        new_entry.space_identifier = s.hi_space;
        new_entry.global           = s.even_lo.global & s.odd_lo.global;
        new_entry.even             = s.even_lo.page;
        new_entry.odd              = s.odd_lo.page;
    end

    // ------------------------------------------------------------------
    // Register read multiplexer, reserved bits as zero
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        unique case (REG_NUM)
            REG_SELECTOR: rd_word = {s.probe_fail, 25'h0000000, s.index};
            REG_REPL:     rd_word = {28'h0000000, rnd_count};
            REG_EVEN_LO:  rd_word = {6'h00, s.even_lo};
            REG_ODD_LO:   rd_word = {6'h00, s.odd_lo};
            REG_PAGE_SEL: rd_word = {7'h00, s.mask, 13'h0000};
            REG_LOCKED:   rd_word = {26'h0000000, s.locked};
            REG_FAULT_VA: rd_word = s.fault_va;
            REG_HIGH:     rd_word = {s.hi_pair, 5'h00, s.hi_space};
            default:      rd_word = 32'h00000000;              // Unmapped or other job
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        tmmu_entry_t e;
        tmmu_page_t  pg;
        logic [31:0] offmask;
        logic        sel_odd;
        e       = s.tlb[hit_idx];
        pg      = e.even;
        offmask = 32'h00000000;
        sel_odd = 1'b0;
        next_s  = s;
        next_s.rvalid = 1'b0;
        next_s.xres   = '0;

        // Register writes; read-only and unmapped numbers are ignored
        if (REG_WE) begin
            unique case (REG_NUM)
                REG_SELECTOR: begin
                    next_s.index = REG_WDATA[SEL_IDX_MSB:0];
                end
                REG_EVEN_LO: begin
                    next_s.even_lo = REG_WDATA[LO_FRAME_MSB:0];
                end
                REG_ODD_LO: begin
                    next_s.odd_lo = REG_WDATA[LO_FRAME_MSB:0];
                end
                REG_PAGE_SEL: begin
                    next_s.mask = REG_WDATA[MASK_MSB:MASK_LSB];
                end
                REG_LOCKED: begin
                    next_s.locked = REG_WDATA[LOCKED_MSB:0];
                end
                REG_HIGH: begin
                    next_s.hi_pair  = REG_WDATA[HI_PAIR_MSB:HI_PAIR_LSB];
                    next_s.hi_space = REG_WDATA[HI_SPACE_MSB:0];
                end
                default: begin
                end
            endcase
        end

        // Buffer instructions, probe first
        if (OP.probe_op) begin
            next_s.probe_fail = ~any_hit;
            if (any_hit) begin
                next_s.index = {2'b00, hit_idx};
            end
        end else if (OP.indexed_read_op) begin
            // Entry selected by the index goes back to the registers
            e = s.tlb[s.index[ENT_IDX_W-1:0]];
            next_s.mask           = e.mask;
            next_s.hi_pair        = e.page_pair_number;
            next_s.hi_space       = e.space_identifier;
            next_s.even_lo.page   = e.even;
            next_s.even_lo.global = e.global;
            next_s.odd_lo.page    = e.odd;
            next_s.odd_lo.global  = e.global;
        end else if (OP.indexed_write_op) begin
            next_s.tlb[s.index[ENT_IDX_W-1:0]] = new_entry;
        end else if (OP.random_write_op) begin
            next_s.tlb[rnd_count] = new_entry;
        end

        // Translation, not served in a probe cycle
        if (XREQ.valid && !OP.probe_op) begin
            e       = s.tlb[hit_idx];
            sel_odd = odd_vec[hit_idx];
            pg      = sel_odd ? e.odd : e.even;
            // Offset is 12 bits for 4 KB up to 24 bits for 16 MB
            offmask = {8'h00, e.mask, 12'hFFF};
            next_s.xres.valid = 1'b1;
            next_s.xres.paddr = ({pg.frame_number, 12'h000} & ~offmask) |
                                (XREQ.vaddr & offmask);
            next_s.xres.cache = pg.cache;
            if (!any_hit) begin
                next_s.xres.refill = 1'b1;
            end else if (!pg.valid) begin
                next_s.xres.invalid = 1'b1;
            end else if (XREQ.store && !pg.dirty) begin
                next_s.xres.modified = 1'b1;
            end
            if (!any_hit || !pg.valid || (XREQ.store && !pg.dirty)) begin
                next_s.xres.paddr          = 32'h00000000;
                next_s.xres.load_miss_exc  = ~XREQ.store;
                next_s.xres.store_miss_exc = XREQ.store;
                next_s.hi_pair             = XREQ.vaddr[31:13];
                if (!EXCEPTION_LEVEL_BIT) begin
                    next_s.fault_va = XREQ.vaddr;
                end
            end
        end

        // Register read answer, one cycle later
        if (REG_RE) begin
            next_s.rdata  = rd_word;
            next_s.rvalid = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            s        <= '0;
            s.locked <= WIRED_RESET;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign REG_RDATA  = s.rdata;
    assign REG_RVALID = s.rvalid;
    assign XRES       = s.xres;

endmodule

`default_nettype wire

/* tb/tmmu_chk_sva.sv */
// Checker on the translation unit ports.
// Assumes a bind onto tmmu_top, one clock.
`timescale 1ns/10ps
`default_nettype none
module tmmu_chk (
    input wire logic                 CLK,
    input wire logic                 NRST,
    input wire logic                 REG_RE,
    input wire logic [4:0]           REG_NUM,
    input wire logic [31:0]          REG_RDATA,
    input wire logic                 REG_RVALID,
    input wire tmmu_pkg::tmmu_op_t   OP,
    input wire tmmu_pkg::tmmu_xreq_t XREQ,
    input wire tmmu_pkg::tmmu_xres_t XRES
);
    import tmmu_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    wire logic f = XRES.refill | XRES.invalid | XRES.modified; // Any fault
    chk_read_answer: assert property (REG_RE |=> REG_RVALID)
        else $error("read not answered");
    chk_sel_rsvd: assert property (REG_RE && REG_NUM == REG_SELECTOR |=> REG_RDATA[30:6] == '0)
        else $error("selector reserved bits");
    chk_lo_rsvd: assert property (REG_RE && REG_NUM[4:1] == 4'h1 |=> REG_RDATA[31:26] == '0)
        else $error("low half reserved bits");
    chk_repl_rsvd: assert property (REG_RE && REG_NUM == REG_REPL |=> REG_RDATA[31:4] == '0)
        else $error("counter reserved bits");
    chk_xres_lat: assert property (XREQ.valid && !OP.probe_op |=> XRES.valid)
        else $error("no translation answer");
    chk_xres_idle: assert property (!XREQ.valid |=> !XRES.valid)
        else $error("answer without request");
    chk_fault_one: assert property (XRES.valid |-> $onehot0({XRES.refill, XRES.invalid, XRES.modified}))
        else $error("several faults");
    chk_fault_side: assert property (XRES.valid && f |-> XRES.paddr == '0
        && XRES.store_miss_exc == $past(XREQ.store) && XRES.load_miss_exc == !$past(XREQ.store))
        else $error("fault fields wrong");
    chk_offset_pass: assert property (XRES.valid && !f |-> XRES.paddr[11:0] == $past(XREQ.vaddr[11:0]))
        else $error("offset changed");
    chk_mod_store: assert property (XRES.modified |-> $past(XREQ.store))
        else $error("modified on load");
    cover property (XRES.refill);
    cover property (XRES.modified);
    cover property (XRES.valid && !f);
endmodule
bind tmmu_top tmmu_chk i_tmmu_chk (.*);
`default_nettype wire

/* tb/tmmu_pipe.sv */
// Pipeline model: retires one valid instruction per cycle while told to.
// Assumes the unit's clock; the strobe changes just after the edge.
`timescale 1ns/10ps
`default_nettype none
module tmmu_pipe (
    input  wire logic CLK,
    input  wire logic RUN,
    output logic      INSTR_VALID
);
    initial INSTR_VALID = 1'b0;
    // Cancelled slots never raise the strobe
    always @(posedge CLK) begin
        INSTR_VALID <= RUN;
    end
endmodule
`default_nettype wire

/* tb/tmmu_top_tb.sv */
// Bench for the translation unit: registers, buffer instructions, lookups.
// Assumes the pipeline model supplies the retired-instruction strobe.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; $display("[ERR] %0t got %h", $time, (a)); end end
module tmmu_top_tb;
    import tmmu_pkg::*;
    localparam logic [31:0] H  = {19'h12345, 5'h00, 8'h5A}; // Pair and space
    localparam logic [31:0] L0 = {6'h00, 20'hABCDE, 3'h3, 3'b011}; // Even, read-only, global
    localparam logic [31:0] L1 = {6'h00, 20'h11111, 3'h2, 3'b100}; // Odd, not valid
    logic        clk = 0, nrst = 0, we = 0, re = 0, exception_level_bit = 0, run = 0, rv, iv;
    logic [4:0]  num = '0;
    logic [31:0] wd = '0, rdata;
    tmmu_op_t    op = '0;
    tmmu_xreq_t  xq = '0;
    tmmu_xres_t  xr;
    int          fails = 0, n_tests = 0, cyc = 0;
    tmmu_top i_tmmu_top (.CLK(clk), .NRST(nrst), .REG_WE(we), .REG_RE(re), .REG_NUM(num),
        .REG_WDATA(wd), .REG_RDATA(rdata), .REG_RVALID(rv), .OP(op), .INSTR_VALID(iv),
        .EXCEPTION_LEVEL_BIT(exception_level_bit), .XREQ(xq), .XRES(xr));
    tmmu_pipe i_tmmu_pipe (.CLK(clk), .RUN(run), .INSTR_VALID(iv));
    initial forever #10 clk = ~clk;
    task wr(input logic [4:0] n, input logic [31:0] d);
        @(posedge clk); we <= 1; num <= n; wd <= d;
        @(posedge clk); we <= 0;
    endtask
    task rd(input logic [4:0] n, input logic [31:0] e);
        @(posedge clk); re <= 1; num <= n;
        @(posedge clk); re <= 0;
        #1 `CHK(rdata, e)
    endtask
    task ins(input logic [3:0] o);
        @(posedge clk); op <= o;
        @(posedge clk); op <= '0;
    endtask
    task xl(input logic st, input logic [31:0] va);
        @(posedge clk); xq <= {1'b1, st, va};
        @(posedge clk); xq <= '0;
        #1;
    endtask
    task step;
        @(posedge clk); run <= 1;
        @(posedge clk); run <= 0;
    endtask
    task t_reset;
        rd(REG_REPL, 32'hF);
        rd(REG_LOCKED, 32'h0);
        rd(REG_PT_PTR, 32'h0);
        rd(5'h07, 32'h0);
    endtask
    task t_entry;
        wr(REG_HIGH, H); wr(REG_EVEN_LO, L0 | 32'h8000_0000); wr(REG_ODD_LO, L1);
        wr(REG_SELECTOR, 32'h3); ins(4'h2); wr(REG_HIGH, 0); wr(REG_EVEN_LO, 0);
        wr(REG_SELECTOR, 0); wr(REG_HIGH, H); ins(4'h8);
        rd(REG_SELECTOR, 32'h3);
        ins(4'h4);
        rd(REG_EVEN_LO, {L0[31:1], 1'b0});
        rd(REG_ODD_LO, L1);
        rd(REG_HIGH, H);
        wr(REG_HIGH, {19'h1, 13'h0}); ins(4'h8);
        rd(REG_SELECTOR, 32'h8000_0003);
        wr(REG_HIGH, H);
    endtask
    task t_xlate;
        xl(0, {H[31:13], 13'h0345});
        `CHK(xr.paddr, {L0[25:6], 12'h345})
        `CHK(xr.cache, CACHE_WB)
        xl(1, {H[31:13], 13'h0345});
        `CHK(xr.modified, 1'b1)
        `CHK(xr.store_miss_exc, 1'b1)
        xl(0, {H[31:13], 13'h1345});
        `CHK(xr.invalid, 1'b1)
        xl(0, 32'h5000);
        `CHK(xr.refill, 1'b1)
        `CHK(xr.load_miss_exc, 1'b1)
        @(posedge clk); exception_level_bit <= 1;
        xl(0, 32'h7000);
        @(posedge clk); exception_level_bit <= 0;
        rd(REG_HIGH, {19'h3, 5'h0, 8'h5A});
        rd(REG_FAULT_VA, 32'h5000);
    endtask
    task t_count;
        wr(REG_REPL, 0); rd(REG_REPL, 32'hF);
        wr(REG_LOCKED, 32'hE); step; rd(REG_REPL, 32'hE);
        step; rd(REG_REPL, 32'hF);
    endtask
    task stop_test;
        if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin fails++; stop_test; end
    end
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1;
        t_reset; t_entry; t_xlate; t_count;
        stop_test;
    end
endmodule
`default_nettype wire
